// [pkg/sdram_pins_pkg.sv]
// Constants, command codes and state types for the synchronous DRAM pin-level front end.
// Assumes one clock at 250 MHz and a controller that drives pins synchronously to it.
// How it works
// - Every input but the asynchronous reset is sampled on the rising edge; same edge steps burst counter and outputs.
// - Clock-gate high lets the clock act inside; low freezes internal activity.
// - Clock-gate low picks power-down, self refresh, active power-down or clock suspend.
// - Clock-gate sampled synchronously; while powered down, the first rising edge that samples it high wakes the part.
// - Power-down and self refresh disable input capture to save standby power.
// - Commands decode only when chip select is registered low; otherwise they are ignored.
// - With chip select high, running bursts finish and byte masks still act.
// - A write byte mask sampled high discards that lane's incoming data.
// - A read byte mask sampled high floats that output byte two clocks later.
// - Mask bit n covers data bits 8n+7 down to 8n.
// - Two bank-select bits choose the bank for activate, read, write, single precharge.
// - Activate captures the row address from the address inputs, twelve bits used.
// - Read or write takes column from bits 7..0; precharge select bit requests auto precharge.
// - Precharge with precharge select bit high closes all banks, low closes one bank.
// - The mode load command takes its op-code from the address inputs.
// - One 32-bit two-way data bus: memory drives on reads, controller on writes.
// - Burst length is one, two, four, eight or full page; full page ends by terminate.
// - Auto precharge closes the accessed row once a fixed-length burst runs out; terminate leaves the row open.
// - Each bank holds 4096 rows of 256 columns of 32 bits.
package sdram_pins_pkg;
  localparam int unsigned BANKS      = 4;
  localparam int unsigned BANK_W     = 2;
  localparam int unsigned ROW_W      = 12;
  localparam int unsigned COL_W      = 8;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned MASK_W     = 4;
  localparam int unsigned LANE_W     = 8;
  localparam int unsigned PRE_BIT    = 10;
  localparam int unsigned READ_LAT   = 2;
  localparam int unsigned MEM_DEPTH  = 64;
  localparam int unsigned MEM_AW     = 6;
  localparam logic [9:0]  FULL_PAGE  = 10'h100;
  // Mode op-code fields: burst length code in bits 2..0.
  localparam int unsigned MR_BURST_LO    = 0;
  localparam int unsigned MR_BURST_HI    = 2;
  localparam logic [2:0]  BURST_LEN_1    = 3'h0;
  localparam logic [2:0]  BURST_LEN_2    = 3'h1;
  localparam logic [2:0]  BURST_LEN_4    = 3'h2;
  localparam logic [2:0]  BURST_LEN_8    = 3'h3;
  localparam logic [2:0]  BURST_LEN_PAGE = 3'h7;
  localparam logic [ADDR_W-1:0] MODE_RESET = 12'h000;
  // Command codes on {row strobe, column strobe, write strobe}, all active low.
  localparam logic [2:0] CMD_NOP  = 3'h7;
  localparam logic [2:0] CMD_ACT  = 3'h3;
  localparam logic [2:0] CMD_RD   = 3'h5;
  localparam logic [2:0] CMD_WR   = 3'h4;
  localparam logic [2:0] CMD_TERM = 3'h6;
  localparam logic [2:0] CMD_PRE  = 3'h2;
  localparam logic [2:0] CMD_REF  = 3'h1;
  localparam logic [2:0] CMD_MRS  = 3'h0;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_READ    = 6'h02,
    ST_WRITE   = 6'h04,
    ST_PDOWN   = 6'h08,
    ST_SELFREF = 6'h10,
    ST_SUSPEND = 6'h20
  } pin_state_t;
endpackage : sdram_pins_pkg

// [hw/sdram_pin_command_interface.sv]
// Device-side pin logic of a four-bank 32-bit single-data-rate synchronous DRAM.
// Assumes the controller drives pins synchronously to i_clk and keeps its own protocol rules.
`timescale 1ns/100ps
`default_nettype none
module sdram_pin_command_interface
  import sdram_pins_pkg::*;
(
  // Clock and reset.
  input  wire logic              i_clk,
  input  wire logic              i_arst_n,
  // Command pins.
  input  wire logic              i_cke,
  input  wire logic              i_cs_n,
  input  wire logic              i_ras_n,
  input  wire logic              i_cas_n,
  input  wire logic              i_we_n,
  input  wire logic [BANK_W-1:0] i_ba,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [MASK_W-1:0] i_dqm,
  // Data bus as three signals.
  input  wire logic [DATA_W-1:0] i_dq,
  output logic      [DATA_W-1:0] o_dq,
  output logic      [DATA_W-1:0] o_dq_oe,
  // Status.
  output logic      [BANKS-1:0]  o_bank_open,
  output logic      [ADDR_W-1:0] o_mode,
  output logic      [5:0]        o_state,
  output logic                   o_power_down,
  output logic                   o_self_refresh,
  output logic                   o_suspend
);

  // ****************************************************************
  // Input capture and command decode
  // ****************************************************************
  logic              cke_q, cke_d;
  logic              clk_act;
  logic [2:0]        cmd;
  logic              sel;
  pin_state_t        st_q, st_d;
  logic              low_pwr;

  assign low_pwr = (st_q == ST_PDOWN) || (st_q == ST_SELFREF);
  // Raw clock-gate pin wakes the part on an edge where the clock does not yet act.
  assign clk_act = i_cke && cke_q;
  // Input buffers are off in low-power states, so no command is decoded there.
  assign sel     = !i_cs_n && clk_act && !low_pwr;
  assign cmd     = sel ? {i_ras_n, i_cas_n, i_we_n} : CMD_NOP;

  always_comb begin
    cke_d = i_cke;
  end

  // ****************************************************************
  // Bank, mode and burst state
  // ****************************************************************
  logic [BANKS-1:0]  open_q, open_d;
  logic [ROW_W-1:0]  row_q [BANKS];
  logic [ROW_W-1:0]  row_d [BANKS];
  logic [ADDR_W-1:0] mode_q, mode_d;
  logic [BANK_W-1:0] bbank_q, bbank_d;
  logic [COL_W-1:0]  col_q, col_d;
  logic [9:0]        left_q, left_d;
  logic              ap_q, ap_d;
  logic [9:0]        blen;
  logic              burst_on;
  logic              burst_end;
  logic              self_ref_go;
  // Burst kind held across a clock suspend.
  pin_state_t        st_resume_q, st_resume_d;

  always_comb begin
    unique case (mode_q[MR_BURST_HI:MR_BURST_LO])
      BURST_LEN_1:    blen = 10'h001;
      BURST_LEN_2:    blen = 10'h002;
      BURST_LEN_4:    blen = 10'h004;
      BURST_LEN_8:    blen = 10'h008;
      BURST_LEN_PAGE: blen = FULL_PAGE;
      default: blen = 10'h001;
    endcase
  end

  assign burst_on  = (st_q == ST_READ) || (st_q == ST_WRITE);
  assign burst_end = burst_on && clk_act && (left_q == 10'h001) && (blen != FULL_PAGE);
  // The falling gate masks the decoded command, so self refresh entry reads the raw strobes.
  assign self_ref_go = !i_cs_n && ({i_ras_n, i_cas_n, i_we_n} == CMD_REF) && (open_q == '0) && !burst_on;

  always_comb begin
    open_d  = open_q;
    row_d   = row_q;
    mode_d  = mode_q;
    bbank_d = bbank_q;
    col_d   = col_q;
    left_d  = left_q;
    ap_d    = ap_q;
    st_d    = st_q;
    unique case (st_q)
      ST_IDLE, ST_READ, ST_WRITE: begin
        // Chip select high leaves a running burst counting on.
        if (burst_on && clk_act) begin
          col_d  = col_q + 8'h01;
          left_d = left_q - 10'h001;
          if (burst_end) begin
            st_d = ST_IDLE;
            if (ap_q) begin
              open_d[bbank_q] = 1'b0;
            end
          end
        end
        unique case (cmd)
          CMD_ACT: begin
            open_d[i_ba] = 1'b1;
            row_d[i_ba]  = i_addr[ROW_W-1:0];
          end
          CMD_RD, CMD_WR: begin
            if (open_q[i_ba]) begin
              bbank_d = i_ba;
              col_d   = i_addr[COL_W-1:0];
              ap_d    = i_addr[PRE_BIT];
              left_d  = blen;
              st_d    = (cmd == CMD_RD) ? ST_READ : ST_WRITE;
            end
          end
          CMD_TERM: begin
            if (burst_on) begin
              st_d = ST_IDLE;
            end
          end
          CMD_PRE: begin
            if (i_addr[PRE_BIT]) begin
              open_d = '0;
            end else begin
              open_d[i_ba] = 1'b0;
            end
          end
          CMD_MRS: begin
            if (open_q == '0) begin
              mode_d = i_addr;
            end
          end
          default: begin
          end
        endcase
        // A falling gate stops the clock acting, so nothing above has moved the state on this edge.
        if (!i_cke && cke_q) begin
          if (self_ref_go) begin
            st_d = ST_SELFREF;
          end else if (burst_on) begin
            st_d = ST_SUSPEND;
          end else begin
            st_d = ST_PDOWN;
          end
        end
      end
      ST_PDOWN, ST_SELFREF: begin
        if (i_cke) begin
          st_d = ST_IDLE;
        end
      end
      ST_SUSPEND: begin
        if (i_cke) begin
          st_d = st_resume_q;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_comb begin
    st_resume_d = st_resume_q;
    if (st_q == ST_READ || st_q == ST_WRITE) begin
      st_resume_d = st_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cke_q       <= 1'b0;
      st_q        <= ST_IDLE;
      st_resume_q <= ST_IDLE;
      open_q      <= '0;
      mode_q      <= MODE_RESET;
      bbank_q     <= '0;
      col_q       <= '0;
      left_q      <= '0;
      ap_q        <= 1'b0;
      for (int i = 0; i < BANKS; i++) begin
        row_q[i] <= '0;
      end
    end else begin
      cke_q       <= cke_d;
      st_q        <= st_d;
      st_resume_q <= st_resume_d;
      open_q      <= open_d;
      mode_q      <= mode_d;
      bbank_q     <= bbank_d;
      col_q       <= col_d;
      left_q      <= left_d;
      ap_q        <= ap_d;
      row_q       <= row_d;
    end
  end

  // ****************************************************************
  // Storage window
  // ****************************************************************
  // Only a small window of the array is modelled: bank, low row and low column bits index it.
  // The full 4096 x 256 x 32 array per bank cannot fit in logic of this size.
  logic [DATA_W-1:0] mem_q [MEM_DEPTH];
  logic [MEM_AW-1:0] waddr;
  logic              wr_go;

  assign waddr = {bbank_q, row_q[bbank_q][0], col_q[2:0]};
  assign wr_go = (st_q == ST_WRITE) && clk_act;

  always_ff @(posedge i_clk) begin
    if (wr_go) begin
      for (int b = 0; b < MASK_W; b++) begin
        if (!i_dqm[b]) begin
          mem_q[waddr][b*LANE_W +: LANE_W] <= i_dq[b*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ****************************************************************
  // Read pipeline through a two-entry buffer
  // ****************************************************************
  // The mask travels with the word so the float lands two clocks after sampling.
  logic              rd_go;
  logic [1:0]        cnt_q, cnt_d;
  logic [DATA_W-1:0] bd_q [2];
  logic [DATA_W-1:0] bd_d [2];
  logic [MASK_W-1:0] bm_q [2];
  logic [MASK_W-1:0] bm_d [2];
  logic              out_rdy;
  logic              out_vld;
  logic [DATA_W-1:0] dq_q, dq_d;
  logic [DATA_W-1:0] oe_q, oe_d;
  logic [MASK_W-1:0] dqm_q, dqm_d;

  assign rd_go   = (st_q == ST_READ) && clk_act;
  // The pad register stalls only on a suspended clock; a suspended word waits in the buffer.
  assign out_rdy = clk_act;
  assign out_vld = cnt_q != 2'h0;

  always_comb begin
    cnt_d = cnt_q;
    bd_d  = bd_q;
    bm_d  = bm_q;
    dq_d  = dq_q;
    oe_d  = clk_act ? '0 : oe_q;
    dqm_d = clk_act ? i_dqm : dqm_q;
    if (out_vld && out_rdy) begin
      dq_d = bd_q[0];
      for (int b = 0; b < MASK_W; b++) begin
        oe_d[b*LANE_W +: LANE_W] = {LANE_W{!bm_q[0][b]}};
      end
      bd_d[0] = bd_q[1];
      bm_d[0] = bm_q[1];
      cnt_d   = cnt_q - 2'h1;
    end
    if (rd_go && cnt_d != 2'h2) begin
      bd_d[cnt_d[0]] = mem_q[waddr];
      bm_d[cnt_d[0]] = dqm_q;
      cnt_d          = cnt_d + 2'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= '0;
      dq_q  <= '0;
      oe_q  <= '0;
      dqm_q <= '0;
      for (int i = 0; i < 2; i++) begin
        bd_q[i] <= '0;
        bm_q[i] <= '0;
      end
    end else begin
      cnt_q <= cnt_d;
      dq_q  <= dq_d;
      oe_q  <= oe_d;
      dqm_q <= dqm_d;
      bd_q  <= bd_d;
      bm_q  <= bm_d;
    end
  end

  // ****************************************************************
  // Status outputs
  // ****************************************************************
  logic [5:0] stat_q;
  logic [2:0] lp_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stat_q <= ST_IDLE;
      lp_q   <= '0;
    end else begin
      stat_q <= st_d;
      lp_q   <= {st_d == ST_PDOWN, st_d == ST_SELFREF, st_d == ST_SUSPEND};
    end
  end

  assign o_dq           = dq_q;
  assign o_dq_oe        = oe_q;
  assign o_bank_open    = open_q;
  assign o_mode         = mode_q;
  assign o_state        = stat_q;
  assign o_power_down   = lp_q[2];
  assign o_self_refresh = lp_q[1];
  assign o_suspend      = lp_q[0];

endmodule : sdram_pin_command_interface
`default_nettype wire

// [sim/sdram_pin_command_interface_assertions.sv]
// Concurrent checks on the pin-level front end of the synchronous DRAM.
// Assumes pins are driven synchronously to i_clk and a correct package.
`timescale 1ns/100ps
`default_nettype none
module sdram_pin_checker
  import sdram_pins_pkg::*;
(
  input wire logic              i_clk, i_arst_n, i_cke, i_cs_n,
  input wire logic              i_ras_n, i_cas_n, i_we_n,
  input wire logic [BANK_W-1:0] i_ba,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [MASK_W-1:0] i_dqm,
  input wire logic [DATA_W-1:0] o_dq_oe,
  input wire logic [BANKS-1:0]  o_bank_open,
  input wire logic [ADDR_W-1:0] o_mode,
  input wire logic [5:0]        o_state,
  input wire logic              o_power_down, o_self_refresh
);
  logic       cke_q;
  logic       take;
  logic [2:0] cmd;
  // The gate is registered, so a command needs it high on two edges.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) cke_q <= 1'b0;
    else cke_q <= i_cke;
  end
  assign take = i_cke && cke_q && !i_cs_n && !o_power_down && !o_self_refresh;
  assign cmd  = {i_ras_n, i_cas_n, i_we_n};
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  sequence act_s; take && cmd == CMD_ACT; endsequence
  sequence rd_s; take && cmd == CMD_RD && o_bank_open[i_ba]; endsequence
  sequence pre_s; take && cmd == CMD_PRE; endsequence
  cs_mask_a: assert property (i_cs_n |=> (o_bank_open & ~$past(o_bank_open)) == '0)
    else $error("bank opened while deselected");
  act_open_a: assert property (act_s |=> o_bank_open[$past(i_ba)])
    else $error("activate did not open bank");
  pre_all_a: assert property (pre_s ##0 i_addr[PRE_BIT] |=> o_bank_open == '0)
    else $error("precharge all left a bank open");
  pre_one_a: assert property (pre_s ##0 !i_addr[PRE_BIT] |=> !o_bank_open[$past(i_ba)])
    else $error("single precharge left bank open");
  mode_load_a: assert property (take && cmd == CMD_MRS && o_bank_open == '0 |=> o_mode == $past(i_addr))
    else $error("mode op-code not taken");
  read_word_a: assert property (rd_s ##0 i_dqm == '0 ##1 i_cke [*2] |=> o_dq_oe == '1)
    else $error("read word not driven");
  lane_float_a: assert property (rd_s ##0 i_dqm[0] ##1 i_cke [*2] |=> o_dq_oe[7:0] == 8'h00)
    else $error("masked read lane driven");
  pd_entry_a: assert property ($fell(i_cke) && o_state == ST_IDLE && o_bank_open == '0 && i_cs_n
    |-> ##[1:2] o_power_down)
    else $error("power-down not entered");
  pd_freeze_a: assert property (o_power_down && !i_cke |=> $stable(o_bank_open) && $stable(o_mode))
    else $error("state changed in power-down");
  pd_wake_a: assert property (o_power_down && i_cke ##1 i_cke |-> ##[0:1] !o_power_down)
    else $error("power-down not left");
  state_hot_a: assert property ($onehot(o_state))
    else $error("state not one-hot");
endmodule : sdram_pin_checker
bind sdram_pin_command_interface sdram_pin_checker u_chk (.i_clk, .i_arst_n, .i_cke, .i_cs_n, .i_ras_n,
  .i_cas_n, .i_we_n, .i_ba, .i_addr, .i_dqm, .o_dq_oe, .o_bank_open, .o_mode, .o_state, .o_power_down,
  .o_self_refresh);
`default_nettype wire

// [sim/sdram_ctrl_model.sv]
// Behavioural memory controller that drives the DRAM pins.
// Assumes the bench calls its tasks one bus cycle at a time.
`timescale 1ns/100ps
`default_nettype none
module sdram_ctrl_model
  import sdram_pins_pkg::*;
(
  input  wire logic              i_clk,
  output logic                   o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n,
  output logic [BANK_W-1:0]      o_ba,
  output logic [ADDR_W-1:0]      o_addr,
  output logic [MASK_W-1:0]      o_dqm,
  output logic [DATA_W-1:0]      o_dq
);
  initial begin
    o_cke = 1'b1;
    o_cs_n = 1'b1;
    {o_ras_n, o_cas_n, o_we_n} = CMD_NOP;
    o_ba = '0;
    o_addr = '0;
    o_dqm = '0;
    o_dq = 32'h5a5a_a5a5;
  end
  // A released data bus toggles every cycle so stale data never looks valid.
  task automatic cyc(input logic sel, input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
                     input logic [3:0] m, input logic drv, input logic [31:0] d);
    @(negedge i_clk);
    o_cs_n = !sel;
    {o_ras_n, o_cas_n, o_we_n} = c;
    o_ba = b;
    o_addr = a;
    o_dqm = m;
    o_dq = drv ? d : ~o_dq;
  endtask : cyc
  // Refresh strobes with the gate falling on the same edge.
  task automatic enter_self_refresh();
    @(negedge i_clk);
    o_cke = 1'b0;
    o_cs_n = 1'b0;
    {o_ras_n, o_cas_n, o_we_n} = CMD_REF;
  endtask : enter_self_refresh
  task automatic gate(input logic v);
    @(negedge i_clk);
    o_cke = v;
  endtask : gate
endmodule : sdram_ctrl_model
`default_nettype wire

// [sim/sdram_pin_command_interface_tb.sv]
// Self-checking bench for the DRAM pin front end.
// Assumes the controller model drives pins and the checker is bound.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module sdram_pin_command_interface_tb
  import sdram_pins_pkg::*;
;
  logic i_clk = 1'b0, i_arst_n = 1'b0, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n;
  logic [1:0] i_ba;
  logic [11:0] i_addr, o_mode;
  logic [3:0] i_dqm, o_bank_open;
  logic [31:0] i_dq, o_dq, o_dq_oe, s = 32'he79047a0;
  logic [31:0] mem [4];
  logic [63:0] exp_q [$];
  logic [5:0] o_state;
  logic o_power_down, o_self_refresh, o_suspend;
  logic [2:0] burst_codes [5] = '{BURST_LEN_1, BURST_LEN_2, BURST_LEN_8, BURST_LEN_PAGE, BURST_LEN_4};
  logic [63:0] exp_w;
  int fail_count = 0, n_checks = 0, cyc_n = 0;
  sdram_pin_command_interface dut (.i_clk, .i_arst_n, .i_cke, .i_cs_n, .i_ras_n, .i_cas_n, .i_we_n,
    .i_ba, .i_addr, .i_dqm, .i_dq, .o_dq, .o_dq_oe, .o_bank_open, .o_mode, .o_state, .o_power_down,
    .o_self_refresh, .o_suspend);
  sdram_ctrl_model ctl (.i_clk, .o_cke(i_cke), .o_cs_n(i_cs_n), .o_ras_n(i_ras_n), .o_cas_n(i_cas_n),
    .o_we_n(i_we_n), .o_ba(i_ba), .o_addr(i_addr), .o_dqm(i_dqm), .o_dq(i_dq));
  initial forever #2 i_clk = ~i_clk;
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : rnd
  function automatic logic [31:0] lanes(input logic [3:0] m);
    for (int i = 0; i < 4; i++) lanes[8*i+:8] = {8{m[i]}};
  endfunction : lanes
  task automatic nop(input int n);
    repeat (n) ctl.cyc(1'b0, CMD_NOP, 2'd0, 12'h000, 4'h0, 1'b0, 32'h0);
  endtask : nop
  task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a);
    ctl.cyc(1'b1, c, b, a, 4'h0, 1'b0, 32'h0);
    nop(2);
  endtask : cmd
  // ****************************************************************
  // Bursts of four on bank 1, row 0; later beats go out deselected.
  // ****************************************************************
  // Write data follows its command by one clock; a suspend may stall the third beat.
  task automatic wr(input logic rm, input logic sus);
    logic [31:0] d;
    logic [31:0] k;
    logic [3:0] m;
    ctl.cyc(1'b1, CMD_WR, 2'd1, 12'h000, 4'h0, 1'b0, 32'h0);
    for (int i = 0; i < 4; i++) begin
      if (sus && i == 2) begin
        ctl.gate(1'b0);
        nop(1);
        `CHK({o_suspend, o_state}, {1'b1, 6'h20})
        ctl.gate(1'b1);
      end
      d = rnd();
      m = rm ? 4'(rnd()) : 4'h0;
      k = lanes(m);
      mem[i] = (mem[i] & k) | (d & ~k);
      ctl.cyc(1'b0, CMD_NOP, 2'd1, 12'h000, m, 1'b1, d);
    end
    nop(1);
  endtask : wr
  task automatic rd(input logic ap);
    logic [31:0] k;
    logic [3:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 4'(rnd());
      if (m == 4'hf) m = 4'h5;
      if (i == 0) m = ap ? 4'h1 : 4'h0;
      k = ~lanes(m);
      exp_q.push_back({k, mem[i] & k});
      ctl.cyc(i == 0, i == 0 ? CMD_RD : CMD_NOP, 2'd1, {1'b0, ap, 10'h000}, m, 1'b0, 32'h0);
    end
    nop(5);
  endtask : rd
  always @(posedge i_clk) begin
    #1;
    if (o_dq_oe !== 32'h0) begin
      if (exp_q.size() == 0) `CHK(o_dq_oe, 32'h0)
      else begin
        exp_w = exp_q.pop_front();
        `CHK({o_dq_oe, o_dq & o_dq_oe}, exp_w)
      end
    end
  end
  always @(posedge i_clk) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (12) @(negedge i_clk);
    i_arst_n = 1'b1;
    `CHK({o_state, o_mode, o_bank_open, o_dq_oe}, {6'h01, 12'h000, 4'h0, 32'h0})
    nop(2);
    foreach (burst_codes[i]) begin
      cmd(CMD_MRS, 2'd0, {9'h000, burst_codes[i]});
      `CHK(o_mode, {9'h000, burst_codes[i]})
    end
    $display("mode load test done");
    cmd(CMD_ACT, 2'd1, 12'h000);
    `CHK(o_bank_open, 4'h2)
    wr(1'b0, 1'b0);
    wr(1'b1, 1'b1);
    rd(1'b0);
    `CHK(o_bank_open, 4'h2)
    rd(1'b1);
    `CHK({o_bank_open, 32'(exp_q.size())}, {4'h0, 32'h0})
    $display("burst test done");
    ctl.cyc(1'b0, CMD_ACT, 2'd2, 12'h000, 4'h0, 1'b0, 32'h0);
    nop(2);
    `CHK(o_bank_open, 4'h0)
    cmd(CMD_ACT, 2'd2, 12'h000);
    cmd(CMD_ACT, 2'd3, 12'hfff);
    cmd(CMD_PRE, 2'd2, 12'h000);
    `CHK(o_bank_open, 4'h8)
    cmd(CMD_PRE, 2'd0, 12'h400);
    `CHK(o_bank_open, 4'h0)
    $display("bank test done");
    ctl.gate(1'b0);
    nop(3);
    `CHK({o_power_down, o_state}, {1'b1, 6'h08})
    cmd(CMD_ACT, 2'd0, 12'h000);
    `CHK(o_bank_open, 4'h0)
    ctl.gate(1'b1);
    nop(3);
    `CHK(o_power_down, 1'b0)
    $display("power-down test done");
    ctl.enter_self_refresh();
    nop(2);
    `CHK({o_self_refresh, o_state}, {1'b1, 6'h10})
    ctl.gate(1'b1);
    nop(2);
    `CHK({o_self_refresh, o_suspend, o_state}, {2'b00, 6'h01})
    $display("self refresh test done");
    finish_test();
  end
endmodule : sdram_pin_command_interface_tb
`undef CHK
`default_nettype wire
